// >>> design/pm_cfg.svh
`ifndef PM_CFG_SVH
`define PM_CFG_SVH

// register byte offsets
`define PM_CTRL_OFF 8'h00
`define PM_STAT_OFF 8'h04
`define PM_MASK_OFF 8'h08

// control register field positions
`define PM_WARN_FLAG_BIT 7
`define PM_WARN_ACK_BIT 6
`define PM_DET_SEL_BIT 5
`define PM_WARN_SEL_BIT 4
`define PM_PART_FLAG_BIT 3
`define PM_PART_ACK_BIT 2
`define PM_STOP_SEL_BIT 0

// interrupt status and mask field positions
`define PM_IRQ_WARN_BIT 0
`define PM_IRQ_PART_BIT 1
`define PM_IRQ_W 2

// reset values
`define PM_CTRL_RST 8'h00
`define PM_IRQ_RST 2'h0
`define PM_WORD_RST 32'h0000_0000

`endif

// >>> design/pm_types_pkg.sv
package pm_types_pkg;

    typedef enum logic [1:0] {
        st_idle,
        st_write,
        st_read_wait,
        st_read_done
    } bus_state_t;

    typedef struct packed {
        logic hit;
        logic [7:0] addr;
    } data_phase_t;

    typedef struct packed {
        logic detect_level_select;
        logic warning_level_select;
    } level_sel_t;

    typedef struct packed {
        logic low_volt_warning_flag;
        logic partial_down_flag;
        logic stop_mode_select;
        logic stop_written;
    } ctrl_state_t;

endpackage

// >>> design/sync_two_ff.sv
`timescale 1ns/1ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule

// >>> design/power_mgmt_status_control_two.sv
`timescale 1ns/1ps
`include "pm_cfg.svh"
module power_mgmt_status_control_two (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic warning_active,
    input wire logic deep_wake,
    output pm_types_pkg::level_sel_t level_select,
    output logic stop_mode_select,
    output logic irq
);
    import pm_types_pkg::*;

    bus_state_t state;
    bus_state_t next_state;
    data_phase_t dph;
    data_phase_t next_dph;
    logic [31:0] next_hrdata;
    ctrl_state_t ctrl;
    ctrl_state_t next_ctrl;
    level_sel_t next_level_select;
    logic [`PM_IRQ_W-1:0] irq_status;
    logic [`PM_IRQ_W-1:0] next_irq_status;
    logic [`PM_IRQ_W-1:0] irq_mask;
    logic [`PM_IRQ_W-1:0] next_irq_mask;
    logic warn_sync;
    logic take;
    logic wr_active;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;
    logic warn_ack;
    logic part_ack;
    logic [`PM_IRQ_W-1:0] events;

    // analog warning level crosses into hclk
    sync_two_ff #(
        .WIDTH(1)
    ) warn_sync_inst (
        .clk(hclk),
        .rst_n(hresetn),
        .async_in(warning_active),
        .sync_out(warn_sync)
    );

    function automatic logic [31:0] read_word(input data_phase_t ph,
                                              input ctrl_state_t c,
                                              input level_sel_t l,
                                              input logic [1:0] st,
                                              input logic [1:0] mk);
        logic [31:0] w;
        w = `PM_WORD_RST;
        if (ph.hit) begin
            unique case (ph.addr)
                `PM_CTRL_OFF: begin
                    w[`PM_WARN_FLAG_BIT] = c.low_volt_warning_flag;
                    w[`PM_DET_SEL_BIT] = l.detect_level_select;
                    w[`PM_WARN_SEL_BIT] = l.warning_level_select;
                    w[`PM_PART_FLAG_BIT] = c.partial_down_flag;
                    w[`PM_STOP_SEL_BIT] = c.stop_mode_select;
                end
                `PM_STAT_OFF: begin
                    w[`PM_IRQ_W-1:0] = st;
                end
                `PM_MASK_OFF: begin
                    w[`PM_IRQ_W-1:0] = mk;
                end
                default: begin
                    w = `PM_WORD_RST;
                end
            endcase
        end
        return w;
    endfunction

    assign take = hsel && htrans[1] && hready;
    assign wr_active = (state == st_write) && dph.hit;
    assign wr_ctrl = wr_active && (dph.addr == `PM_CTRL_OFF);
    assign wr_stat = wr_active && (dph.addr == `PM_STAT_OFF);
    assign wr_mask = wr_active && (dph.addr == `PM_MASK_OFF);
    assign warn_ack = wr_ctrl && hwdata[`PM_WARN_ACK_BIT];
    assign part_ack = wr_ctrl && hwdata[`PM_PART_ACK_BIT];
    assign hreadyout = (state != st_read_wait);
    assign hresp = 1'b0;

    // bus slave sequencing
    always_comb begin
        next_state = state;
        next_dph = dph;
        next_hrdata = hrdata;
        unique case (state)
            st_read_wait: begin
                next_hrdata = read_word(dph, ctrl, level_select,
                                        irq_status, irq_mask);
                next_state = st_read_done;
            end
            st_idle, st_write, st_read_done: begin
                if (take) begin
                    next_dph.hit = (haddr[31:8] == 24'h00_0000);
                    next_dph.addr = haddr[7:0];
                    next_state = hwrite ? st_write : st_read_wait;
                end else begin
                    next_state = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_idle;
            dph <= '0;
            hrdata <= `PM_WORD_RST;
        end else begin
            state <= next_state;
            dph <= next_dph;
            hrdata <= next_hrdata;
        end
    end

    // control and flag state
    always_comb begin
        next_ctrl = ctrl;
        next_level_select = level_select;
        if (warn_sync) begin
            next_ctrl.low_volt_warning_flag = 1'b1;
        end else if (warn_ack) begin
            next_ctrl.low_volt_warning_flag = 1'b0;
        end
        if (deep_wake) begin
            next_ctrl.partial_down_flag = 1'b1;
        end else if (part_ack) begin
            next_ctrl.partial_down_flag = 1'b0;
        end
        if (wr_ctrl) begin
            next_level_select.detect_level_select = hwdata[`PM_DET_SEL_BIT];
            next_level_select.warning_level_select =
                hwdata[`PM_WARN_SEL_BIT];
        end
        if (wr_ctrl && !ctrl.stop_written) begin
            next_ctrl.stop_mode_select = hwdata[`PM_STOP_SEL_BIT];
            next_ctrl.stop_written = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= '0;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            level_select <= '0;
        end else begin
            level_select <= next_level_select;
        end
    end

    assign stop_mode_select = ctrl.stop_mode_select;

    // interrupt status and mask
    always_comb begin
        events = '0;
        events[`PM_IRQ_WARN_BIT] = next_ctrl.low_volt_warning_flag &&
                                   !ctrl.low_volt_warning_flag;
        events[`PM_IRQ_PART_BIT] = next_ctrl.partial_down_flag &&
                                   !ctrl.partial_down_flag;
        next_irq_status = irq_status;
        if (wr_stat) begin
            next_irq_status = irq_status & ~hwdata[`PM_IRQ_W-1:0];
        end
        next_irq_status = next_irq_status | events;
        next_irq_mask = irq_mask;
        if (wr_mask) begin
            next_irq_mask = hwdata[`PM_IRQ_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= `PM_IRQ_RST;
            irq_mask <= `PM_IRQ_RST;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
        end
    end

    assign irq = |(irq_status & irq_mask);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn || !por_n);

    logic rd_ctrl_done;
    assign rd_ctrl_done = (state == st_read_done) && dph.hit &&
                          (dph.addr == `PM_CTRL_OFF);

    warn_flag_set_a: assert property (
        warn_sync |=> ctrl.low_volt_warning_flag
    ) else $error("warning flag not set by active indication");

    warn_after_rst_a: assert property (
        ($rose(hresetn) || $rose(warning_active)) && warning_active
        ##1 warning_active [*2] |=> ctrl.low_volt_warning_flag
    ) else $error("warning flag missing after indication settled");

    warn_ack_clr_a: assert property (
        warn_ack && !warn_sync |=> !ctrl.low_volt_warning_flag
    ) else $error("warning flag not cleared by acknowledge");

    warn_flag_hold_a: assert property (
        ctrl.low_volt_warning_flag && !(warn_ack && !warn_sync)
        |=> ctrl.low_volt_warning_flag
    ) else $error("warning flag dropped without acknowledge");

    det_sel_wr_a: assert property (
        wr_ctrl |=> level_select.detect_level_select ==
                    $past(hwdata[`PM_DET_SEL_BIT])
    ) else $error("detect level select not written");

    warn_sel_wr_a: assert property (
        !wr_ctrl |=> $stable(level_select.warning_level_select)
    ) else $error("warning level select changed without write");

    part_flag_set_a: assert property (
        deep_wake |=> ctrl.partial_down_flag ##1
        (ctrl.partial_down_flag || $past(part_ack))
    ) else $error("partial-down flag not set on wake");

    part_ack_clr_a: assert property (
        part_ack && !deep_wake |=> !ctrl.partial_down_flag
    ) else $error("partial-down flag not cleared");

    stop_first_wr_a: assert property (
        wr_ctrl && !ctrl.stop_written
        |=> stop_mode_select == $past(hwdata[`PM_STOP_SEL_BIT])
    ) else $error("first stop select write not taken");

    stop_locked_a: assert property (
        ctrl.stop_written |=> $stable(stop_mode_select) && ctrl.stop_written
    ) else $error("stop select changed after first write");

    ctrl_zero_bits_a: assert property (
        rd_ctrl_done |-> hrdata[`PM_WARN_ACK_BIT] == 1'b0 &&
                         hrdata[`PM_PART_ACK_BIT] == 1'b0 &&
                         hrdata[1] == 1'b0 && hrdata[31:8] == 24'h00_0000
    ) else $error("write-only or unused bits read nonzero");

    read_wait_one_a: assert property (
        state == st_read_wait |-> !hreadyout ##1 hreadyout
    ) else $error("read not answered after one wait state");

    warn_ack_cov: cover property (
        ctrl.low_volt_warning_flag && warn_ack && !warn_sync
    );
    stop_rewrite_cov: cover property (
        ctrl.stop_written && wr_ctrl
    );
    part_wake_cov: cover property (
        deep_wake ##[1:20] part_ack
    );
    irq_raise_cov: cover property (
        $rose(irq)
    );
endmodule

// >>> tb/power_mgmt_status_control_two_tb.sv
`timescale 1ns/1ps
`include "pm_cfg.svh"
module power_mgmt_status_control_two_tb;
    import pm_types_pkg::*;
    localparam logic [7:0] CT = `PM_CTRL_OFF;
    localparam logic [7:0] ST = `PM_STAT_OFF;
    localparam logic [7:0] MK = `PM_MASK_OFF;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic por_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic warning_active = 1'b0;
    logic deep_wake = 1'b0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    level_sel_t level_select;
    logic stop_mode_select;
    logic irq;
    logic [31:0] rd;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;

    always #10 hclk = ~hclk;

    power_mgmt_status_control_two u_power_mgmt_status_control_two (
        .hclk(hclk),
        .hresetn(hresetn),
        .por_n(por_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(3'h2),
        .hready(hreadyout),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .warning_active(warning_active),
        .deep_wake(deep_wake),
        .level_select(level_select),
        .stop_mode_select(stop_mode_select),
        .irq(irq)
    );

    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // cut a hang short
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // level selects, stop select, irq sampled mid-cycle
    task automatic chk_pin(input logic [3:0] exp);
        logic [3:0] got;
        @(negedge hclk);
        got = {level_select, stop_mode_select, irq};
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
        @(posedge hclk);
    endtask

    // hready is stable between edges, so look mid-cycle
    task automatic wait_ready();
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        rd = hrdata;
        @(posedge hclk);
    endtask

    task automatic bus_cycle(input logic [7:0] a, input logic w,
                             input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        bus_cycle(a, 1'b1, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus_cycle(a, 1'b0, 32'h0);
        chk(rd, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic apply_reset(input logic power);
        hresetn <= 1'b0;
        por_n <= ~power;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        repeat (5) @(posedge hclk);
    endtask

    initial begin
        @(posedge hclk);
        apply_reset(1'b1);
        rd_chk(CT, 32'h00);
        chk_pin(4'h0);
        bus_write(CT, 32'h31);
        rd_chk(CT, 32'h31);
        chk_pin(4'hE);
        bus_write(CT, 32'hCE);
        rd_chk(CT, 32'h01);
        chk_pin(4'h2);
        bus_write(CT, 32'h12);
        rd_chk(CT, 32'h11);
        rd_chk(8'h0C, 32'h0);
        // warning flag set, held, acknowledged
        warning_active <= 1'b1;
        repeat (4) @(posedge hclk);
        rd_chk(CT, 32'h91);
        bus_write(CT, 32'h40);
        rd_chk(CT, 32'h81);
        rd_chk(ST, 32'h1);
        bus_write(MK, 32'h1);
        chk_pin(4'h3);
        bus_write(ST, 32'h1);
        chk_pin(4'h2);
        warning_active <= 1'b0;
        repeat (4) @(posedge hclk);
        rd_chk(CT, 32'h81);
        bus_write(CT, 32'h40);
        rd_chk(CT, 32'h01);
        // wake from deep stop
        bus_write(MK, 32'h2);
        deep_wake <= 1'b1;
        @(posedge hclk);
        deep_wake <= 1'b0;
        rd_chk(CT, 32'h09);
        chk_pin(4'h3);
        bus_write(CT, 32'h04);
        rd_chk(CT, 32'h01);
        bus_write(ST, 32'h2);
        chk_pin(4'h2);
        // plain reset keeps level selects
        bus_write(CT, 32'h30);
        warning_active <= 1'b1;
        apply_reset(1'b0);
        rd_chk(CT, 32'hB0);
        chk_pin(4'hC);
        bus_write(CT, 32'h31);
        rd_chk(CT, 32'hB1);
        warning_active <= 1'b0;
        apply_reset(1'b1);
        rd_chk(CT, 32'h00);
        chk_pin(4'h0);
        finish_test();
    end
endmodule
